// ### uadma_pkg.sv
// package: register map, fields and reset values of the auto dma block
package uadma_pkg;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_EVENT   = 4'h1;
    localparam logic [3:0] ADDR_MASK    = 4'h2;
    localparam logic [3:0] ADDR_MIRROR  = 4'h3;
    localparam logic [3:0] ADDR_COUNT   = 4'h4;
    localparam logic [3:0] ADDR_ERROR   = 4'h5;
    localparam int CTL_DEN   = 7;
    localparam int CTL_IGN   = 6;
    localparam int CTL_INITIAL_TOGGLE  = 5;
    localparam int CTL_AUTO_DMA_MODE  = 4;
    localparam int CTL_DMOD  = 3;
    localparam int EV_HALT   = 0;
    localparam int EV_ERR    = 1;
    localparam int EV_CNT    = 2;
    localparam int EV_SHORT  = 3;
    localparam int EV_EXPECTED_TOGGLE   = 5;
    localparam int ERR_AEH   = 7;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [3:0] MASK_RST    = 4'h0;
    localparam logic [7:0] COUNT_RST   = 8'h00;
    localparam logic [6:0] ERRCNT_RST  = 7'h00;
    localparam logic [6:0] FIFO_FULL   = 7'h40;
    typedef enum logic [1:0] {UA_CMD_NONE, UA_CMD_RETRY, UA_CMD_FLUSH}
        uadma_cmd_t;
endpackage

// ### uadma_ep_if.sv
// interface: endpoint-side signals of the selected channel
`timescale 1ns/100ps
`default_nettype none
interface uadma_ep_if;
    logic       pktDone;
    logic       isTx;
    logic       rxErr;
    logic       txAck;
    logic       pktToggle;
    logic [6:0] pktLen;
    logic       dmaBusy;
    logic       epEnable;
    logic       useDmaToggle;
    logic       dmaToggle;
    uadma_pkg::uadma_cmd_t cmd;
    modport core (input pktDone, isTx, rxErr, txAck, pktToggle, pktLen,
                  dmaBusy,
                  output epEnable, useDmaToggle, dmaToggle, cmd);
    modport seq  (output pktDone, isTx, rxErr, txAck, pktToggle, pktLen,
                  dmaBusy,
                  input epEnable, useDmaToggle, dmaToggle, cmd);
endinterface
`default_nettype wire

// ### uadma_ep_seq.sv
// module: registers the endpoint packet signals for the core, passes dma busy through
`timescale 1ns/100ps
`default_nettype none
module uadma_ep_seq (
    input  wire logic  ref_clk,
    input  wire logic  srst,
    input  wire logic  clkEn,
    input  wire logic  epPktDone,
    input  wire logic  epIsTx,
    input  wire logic  epRxErr,
    input  wire logic  epTxAck,
    input  wire logic  epToggle,
    input  wire logic  [6:0] epLen,
    input  wire logic  dmaCycleBusy,
    uadma_ep_if.seq    ep
);
    import uadma_pkg::*;
    // registered so every packet event reaches the core in one cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ep.pktDone   <= 1'b0;
            ep.isTx      <= 1'b0;
            ep.rxErr     <= 1'b0;
            ep.txAck     <= 1'b0;
            ep.pktToggle <= 1'b0;
            ep.pktLen    <= 7'h00;
        end else if (clkEn) begin
            ep.pktDone   <= epPktDone;
            ep.isTx      <= epIsTx;
            ep.rxErr     <= epRxErr;
            ep.txAck     <= epTxAck;
            ep.pktToggle <= epToggle;
            ep.pktLen    <= epLen;
        end
    end
    assign ep.dmaBusy = dmaCycleBusy;
endmodule
`default_nettype wire

// ### uadma_core.sv
// module: auto dma sequencing, event flags and register port
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module uadma_core (
    input  wire logic  ref_clk,
    input  wire logic  srst,
    input  wire logic  clkEn,
    input  wire logic  [3:0] regAddr,
    input  wire logic  [7:0] regWrData,
    input  wire logic  regWrite,
    input  wire logic  regRead,
    output logic       [7:0] regRdData,
    input  wire logic  interfaceSelectPin,
    input  wire logic  fifoAccess,
    input  wire logic  epRegAccess,
    input  wire logic  isoMode,
    input  wire logic  [7:0] endpointTransmitStatus,
    input  wire logic  [7:0] endpointReceiveStatus,
    input  wire logic  epPktDone,
    input  wire logic  epIsTx,
    input  wire logic  epRxErr,
    input  wire logic  epTxAck,
    input  wire logic  epToggle,
    input  wire logic  [6:0] epLen,
    input  wire logic  dmaCycleBusy,
    output logic       altDmaEvent,
    output logic       epEnable,
    output logic       useDmaToggle,
    output logic       dmaToggle,
    output uadma_pkg::uadma_cmd_t epCmd,
    output logic       [2:0] sourceEndpointSelect,
    output logic       autoActive
);
    import uadma_pkg::*;
    typedef enum logic [1:0] {UA_IDLE, UA_RUN, UA_DRAIN} uadma_state_t;

    uadma_ep_if ep();
    uadma_ep_seq seqInst (
        .ref_clk      (ref_clk),
        .srst         (srst),
        .clkEn        (clkEn),
        .epPktDone    (epPktDone),
        .epIsTx       (epIsTx),
        .epRxErr      (epRxErr),
        .epTxAck      (epTxAck),
        .epToggle     (epToggle),
        .epLen        (epLen),
        .dmaCycleBusy (dmaCycleBusy),
        .ep           (ep)
    );

    logic [7:0]   dmaControl;
    logic [3:0]   eventBits;
    logic         expectedToggle;
    logic [3:0]   eventMask;
    logic [7:0]   packetCount;
    logic         autoErrorHandling;
    logic [6:0]   errPreset;
    logic [6:0]   errCounter;
    uadma_state_t state;
    uadma_state_t next_state;
    logic [3:0]   setEvents;
    logic         wrCtl;
    logic         wrEvt;
    logic         wrCnt;
    logic         denBit;
    logic         admaBit;
    logic         abortNow;
    logic         denNext;
    logic         pktBad;
    logic         tglMiss;
    logic         pktGood;
    logic         anyEvent;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        hit = (a == b);
    endfunction

    assign wrCtl = regWrite && hit(regAddr, ADDR_CONTROL);
    assign wrEvt = regWrite && hit(regAddr, ADDR_EVENT);
    assign wrCnt = regWrite && hit(regAddr, ADDR_COUNT);
    assign denBit  = dmaControl[CTL_DEN];
    assign admaBit = dmaControl[CTL_AUTO_DMA_MODE];
    assign anyEvent = |eventBits;
    assign autoActive = (state != UA_IDLE);

    // packet outcome of the selected endpoint
    assign pktBad = ep.isTx ? !ep.txAck : ep.rxErr;
    // compared against the toggle before it advances
    assign tglMiss = (ep.pktToggle != expectedToggle)
                     && !(!ep.isTx && dmaControl[CTL_IGN]);
    assign pktGood = ep.pktDone && !pktBad && !tglMiss;

    // enable as it stands after this edge, so a clearing write stops at once
    assign denNext = wrCtl ? (regWrData[CTL_DEN] && !interfaceSelectPin)
                           : denBit;
    // immediate-stop causes: enable dropped, fifo access, or endpoint register poke with auto mode set
    assign abortNow = autoActive && (!denNext
                      || fifoAccess
                      || (epRegAccess && admaBit));

    // control register; serial mode makes the enable write inert
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dmaControl <= CONTROL_RST;
        end else if (clkEn && wrCtl) begin
            dmaControl <= regWrData;
            if (interfaceSelectPin) begin
                dmaControl[CTL_DEN] <= 1'b0;
            end
        end
    end

    // sequencer
    always_comb begin
        next_state = state;
        case (state)
            UA_IDLE: begin
                if (denBit && admaBit && !anyEvent) begin
                    next_state = UA_RUN;
                end
            end
            UA_RUN: begin
                if (abortNow || anyEvent) begin
                    next_state = UA_IDLE;
                end else if (!admaBit) begin
                    next_state = UA_DRAIN;
                end
            end
            UA_DRAIN: begin
                // wait for the current dma cycle before going idle
                if (abortNow || !ep.dmaBusy) begin
                    next_state = UA_IDLE;
                end
            end
            default: next_state = UA_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= UA_IDLE;
        end else if (clkEn) begin
            state <= next_state;
        end
    end

    // event sources for this cycle
    always_comb begin
        setEvents = 4'h0;
        // halt raised as the engine reaches idle by an abort or from drain, not when an event ends the run
        if (autoActive && next_state == UA_IDLE && !anyEvent
            && (abortNow || state == UA_DRAIN)) begin
            setEvents[EV_HALT] = 1'b1;
        end
        if (state == UA_RUN && ep.pktDone && (pktBad || tglMiss)) begin
            if (!autoErrorHandling || errCounter == 7'h00 || tglMiss) begin
                setEvents[EV_ERR] = 1'b1;
            end
        end
        if (state == UA_RUN && pktGood && packetCount == 8'h00) begin
            setEvents[EV_CNT] = 1'b1;
        end
        if (state == UA_RUN && pktGood && !ep.isTx
            && ep.pktLen < FIFO_FULL) begin
            setEvents[EV_SHORT] = 1'b1;
        end
    end

    // sticky events: a new event beats a clearing write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            eventBits <= 4'h0;
        end else if (clkEn) begin
            if (wrEvt) begin
                eventBits <= (eventBits & ~regWrData[3:0]) | setEvents;
            end else begin
                eventBits <= eventBits | setEvents;
            end
        end
    end

    // unmasked events pulse the alternate event flag
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            altDmaEvent <= 1'b0;
        end else if (clkEn) begin
            altDmaEvent <= |(setEvents & eventMask);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            eventMask <= MASK_RST;
        end else if (clkEn && regWrite && hit(regAddr, ADDR_MASK)) begin
            eventMask <= regWrData[3:0];
        end
    end

    // expected toggle: control write wins over the packet flip
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            expectedToggle <= 1'b0;
        end else if (clkEn) begin
            if (wrCtl) begin
                expectedToggle <= regWrData[CTL_INITIAL_TOGGLE];
            end else if (ep.pktDone && !pktBad) begin
                expectedToggle <= !expectedToggle;
            end
        end
    end

    // packet count: write wins, never below zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            packetCount <= COUNT_RST;
        end else if (clkEn) begin
            if (wrCnt) begin
                packetCount <= regWrData;
            end else if (state == UA_RUN && pktGood
                         && packetCount != 8'h00) begin
                packetCount <= packetCount - 8'h01;
            end
        end
    end

    // error preset; ignored while auto mode runs
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            autoErrorHandling <= 1'b0;
            errPreset         <= ERRCNT_RST;
        end else if (clkEn && regWrite && hit(regAddr, ADDR_ERROR)
                     && !autoActive) begin
            autoErrorHandling <= regWrData[ERR_AEH];
            errPreset         <= regWrData[6:0];
        end
    end

    // consecutive error counter
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            errCounter <= ERRCNT_RST;
        end else if (clkEn) begin
            if (state != UA_RUN || pktGood) begin
                errCounter <= errPreset;
            end else if (ep.pktDone && pktBad && autoErrorHandling
                         && errCounter != 7'h00) begin
                errCounter <= errCounter - 7'h01;
            end
        end
    end

    // endpoint commands: retry or flush a bad packet, drop iso transmit errors
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            epCmd <= UA_CMD_NONE;
        end else if (clkEn) begin
            epCmd <= UA_CMD_NONE;
            if (state == UA_RUN && ep.pktDone && pktBad
                && autoErrorHandling && !setEvents[EV_ERR]) begin
                if (ep.isTx && !isoMode) begin
                    epCmd <= UA_CMD_RETRY;
                end else if (!ep.isTx) begin
                    epCmd <= UA_CMD_FLUSH;
                end
            end
        end
    end

    assign epEnable = (state == UA_RUN);
    // auto transmit drives the pid from our toggle, not the endpoint bit
    assign useDmaToggle = (state != UA_IDLE);
    assign dmaToggle = expectedToggle;
    assign sourceEndpointSelect = dmaControl[2:0];
    assign ep.epEnable = epEnable;
    assign ep.useDmaToggle = useDmaToggle;
    assign ep.dmaToggle = dmaToggle;
    assign ep.cmd = epCmd;

    // read port; mirror read has no side effects
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            regRdData <= 8'h00;
        end else if (clkEn && regRead) begin
            case (regAddr)
                ADDR_CONTROL: regRdData <= dmaControl;
                ADDR_EVENT:   regRdData <= {2'b00, expectedToggle, 1'b0,
                                            eventBits};
                ADDR_MASK:    regRdData <= {4'h0, eventMask};
                // odd source codes select a receive endpoint
                ADDR_MIRROR:  regRdData <= dmaControl[0]
                                           ? endpointReceiveStatus
                                           : endpointTransmitStatus;
                ADDR_COUNT:   regRdData <= packetCount;
                ADDR_ERROR:   regRdData <= {autoErrorHandling,
                                  autoActive ? errCounter : errPreset};
                default:      regRdData <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### uadma_core_sva.sv
// checker: port-level assertions for the auto dma core
`timescale 1ns/100ps
`default_nettype none
module uadma_core_sva (
    input wire logic              ref_clk,
    input wire logic              srst,
    input wire logic [3:0]        regAddr,
    input wire logic [7:0]        regWrData,
    input wire logic              regWrite,
    input wire logic              interfaceSelectPin,
    input wire logic              fifoAccess,
    input wire logic              epRegAccess,
    input wire logic              isoMode,
    input wire logic              altDmaEvent,
    input wire logic              epEnable,
    input wire logic              useDmaToggle,
    input wire logic              dmaToggle,
    input wire uadma_pkg::uadma_cmd_t epCmd,
    input wire logic              autoActive
);
    import uadma_pkg::*;
    logic ctlWr;
    logic maskNz;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    assign ctlWr = regWrite && (regAddr == ADDR_CONTROL);
    // shadow of the mask, so a pulse can be tied to an enabled event
    always_ff @(posedge ref_clk) begin
        if (srst)
            maskNz <= 1'b0;
        else if (regWrite && regAddr == ADDR_MASK)
            maskNz <= |regWrData[3:0];
    end
    a_serial_no_start: assert property (
        ctlWr && interfaceSelectPin && !autoActive |=> !autoActive [*2])
        else $error("auto dma started in serial mode");
    a_enable_clear_stop: assert property (
        ctlWr && !regWrData[CTL_DEN] && autoActive |=> !autoActive)
        else $error("auto dma kept running after enable cleared");
    a_fifo_access_stop: assert property (
        fifoAccess && autoActive |=> !autoActive)
        else $error("auto dma kept running after fifo access");
    a_ep_access_stop: assert property (
        epRegAccess && epEnable |=> !autoActive)
        else $error("auto dma kept running after endpoint access");
    a_toggle_write_wins: assert property (
        ctlWr |=> dmaToggle == $past(regWrData[CTL_INITIAL_TOGGLE]))
        else $error("expected toggle not loaded by control write");
    a_pid_source_sel: assert property (
        useDmaToggle == autoActive)
        else $error("toggle source does not follow auto state");
    a_alt_masked_only: assert property (
        altDmaEvent |-> maskNz || $past(maskNz))
        else $error("alternate event raised with all events masked");
    a_retry_non_iso: assert property (
        epCmd == UA_CMD_RETRY |-> !$past(isoMode))
        else $error("retry issued for isochronous endpoint");
endmodule
bind uadma_core uadma_core_sva i_uadma_core_sva (
    .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite),
    .interfaceSelectPin(interfaceSelectPin), .fifoAccess(fifoAccess),
    .epRegAccess(epRegAccess), .isoMode(isoMode),
    .altDmaEvent(altDmaEvent), .epEnable(epEnable),
    .useDmaToggle(useDmaToggle), .dmaToggle(dmaToggle),
    .epCmd(epCmd), .autoActive(autoActive));
`default_nettype wire

// ### uadma_ep_model.sv
// partner model: endpoint engine and dma controller beside the core
`timescale 1ns/100ps
`default_nettype none
module uadma_ep_model #(
    parameter int BUSY_CYCLES = 10
) (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       epEnable,
    input  wire logic       go,
    input  wire logic [3:0] pktCfg,
    input  wire logic [6:0] pktLen,
    output logic            epPktDone,
    output logic            epIsTx,
    output logic            epRxErr,
    output logic            epTxAck,
    output logic            epToggle,
    output logic [6:0]      epLen,
    output logic            dmaCycleBusy
);
    logic       pend;
    logic [4:0] busy;
    assign dmaCycleBusy = (busy != 5'h00);
    // a packet only moves while the core enables the endpoint
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pend <= 1'b0;
            busy <= 5'h00;
            epPktDone <= 1'b0;
        end else begin
            epPktDone <= pend && epEnable;
            if (go)
                pend <= 1'b1;
            else if (pend && epEnable)
                pend <= 1'b0;
            if (pend && epEnable)
                busy <= 5'(BUSY_CYCLES);
            else if (busy != 5'h00)
                busy <= busy - 5'h01;
        end
    end
    // qualifiers flip outside the pulse so stale values cannot pass
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {epIsTx, epRxErr, epTxAck, epToggle} <= 4'h0;
            epLen <= 7'h00;
        end else if (pend && epEnable) begin
            {epIsTx, epRxErr, epTxAck, epToggle} <= pktCfg;
            epLen <= pktLen;
        end else begin
            {epIsTx, epRxErr, epTxAck, epToggle} <=
                ~{epIsTx, epRxErr, epTxAck, epToggle};
            epLen <= ~epLen;
        end
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// testbench: register-level tests of the auto dma core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import uadma_pkg::*;
    logic       ref_clk, srst, clkEn, regWrite, regRead, isoMode;
    logic       interfaceSelectPin, fifoAccess, epRegAccess, go;
    logic       epPktDone, epIsTx, epRxErr, epTxAck, epToggle;
    logic       dmaCycleBusy, altDmaEvent, epEnable, useDmaToggle;
    logic       dmaToggle, autoActive, altSeen, flushSeen, retrySeen;
    logic [3:0] regAddr, pktCfg;
    logic [6:0] epLen, pktLen;
    logic [7:0] regWrData, regRdData;
    logic [7:0] endpointTransmitStatus, endpointReceiveStatus;
    logic [2:0] sourceEndpointSelect;
    uadma_cmd_t epCmd;
    int         fails, cmp_count;
    uadma_core i_uadma_core (.*);
    uadma_ep_model i_uadma_ep_model (.ref_clk(ref_clk), .srst(srst),
        .epEnable(epEnable), .go(go), .pktCfg(pktCfg), .pktLen(pktLen),
        .epPktDone(epPktDone), .epIsTx(epIsTx), .epRxErr(epRxErr),
        .epTxAck(epTxAck), .epToggle(epToggle), .epLen(epLen),
        .dmaCycleBusy(dmaCycleBusy));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (srst) begin
            {altSeen, flushSeen, retrySeen} <= 3'b000;
        end else begin
            if (altDmaEvent === 1'b1) altSeen <= 1'b1;
            if (epCmd === UA_CMD_FLUSH) flushSeen <= 1'b1;
            if (epCmd === UA_CMD_RETRY) retrySeen <= 1'b1;
        end
    end
    task automatic chk(input logic [7:0] seen, exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    // read data appears in the cycle after the strobe and holds until the next read
    task automatic rd(input logic [3:0] a, input logic [7:0] e, m);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        chk(regRdData & m, e, $sformatf("reg %h", a));
    endtask
    task automatic flag(input logic f, e, input string what);
        chk({7'h00, f}, {7'h00, e}, what);
    endtask
    task automatic pkt(input logic [3:0] c, input logic [6:0] l);
        int n;
        n = 0;
        @(posedge ref_clk);
        pktCfg <= c;
        pktLen <= l;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        while (epPktDone !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        flag(epPktDone, 1'b1, "packet");
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic summarize;
        $display("fails %0d cmp_count %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        summarize();
    end
    initial begin
        {srst, clkEn} = 2'b11;
        {regWrite, regRead, isoMode, interfaceSelectPin} = 4'h0;
        {fifoAccess, epRegAccess, go, pktCfg, regAddr} = 11'h000;
        {regWrData, pktLen, fails, cmp_count} = '0;
        endpointTransmitStatus = 8'ha5;
        endpointReceiveStatus = 8'h5a;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rd(ADDR_CONTROL, CONTROL_RST, 8'hff);
        rd(ADDR_EVENT, 8'h00, 8'hff);
        rd(ADDR_MASK, {4'h0, MASK_RST}, 8'hff);
        rd(ADDR_COUNT, COUNT_RST, 8'hff);
        rd(ADDR_ERROR, {1'b0, ERRCNT_RST}, 8'hff);
        $display("test reset done");
        @(posedge ref_clk) interfaceSelectPin <= 1'b1;
        wr(ADDR_CONTROL, 8'h90);
        rd(ADDR_CONTROL, 8'h10, 8'hff);
        @(posedge ref_clk) interfaceSelectPin <= 1'b0;
        wr(ADDR_CONTROL, 8'h20);
        rd(ADDR_EVENT, 8'h20, 8'hff);
        wr(ADDR_ERROR, 8'h83);
        rd(ADDR_ERROR, 8'h83, 8'hff);
        wr(ADDR_MASK, 8'h0f);
        wr(ADDR_COUNT, 8'h01);
        wr(ADDR_CONTROL, 8'h90);
        wr(ADDR_ERROR, 8'h00);
        rd(ADDR_ERROR, 8'h83, 8'hff);
        pkt(4'b0000, 7'h40);
        rd(ADDR_COUNT, 8'h00, 8'hff);
        rd(ADDR_EVENT, 8'h20, 8'hff);
        pkt(4'b0101, 7'h40);
        rd(ADDR_ERROR, 8'h82, 8'hff);
        rd(ADDR_EVENT, 8'h20, 8'hff);
        flag(flushSeen, 1'b1, "flush");
        pkt(4'b0001, 7'h0a);
        rd(ADDR_EVENT, 8'h0c, 8'hff);
        rd(ADDR_COUNT, 8'h00, 8'hff);
        flag(altSeen, 1'b1, "alt event");
        rd(ADDR_ERROR, 8'h83, 8'hff);
        wr(ADDR_CONTROL, 8'h90);
        @(posedge ref_clk);
        #1;
        flag(autoActive, 1'b0, "auto");
        wr(ADDR_EVENT, 8'h0f);
        rd(ADDR_EVENT, 8'h00, 8'h0f);
        $display("test auto run done");
        wr(ADDR_COUNT, 8'h05);
        wr(ADDR_CONTROL, 8'h90);
        pkt(4'b0001, 7'h40);
        rd(ADDR_EVENT, 8'h02, 8'h0f);
        wr(ADDR_EVENT, 8'h0f);
        wr(ADDR_CONTROL, 8'hd0);
        pkt(4'b0001, 7'h40);
        rd(ADDR_EVENT, 8'h00, 8'h0f);
        flag(autoActive, 1'b1, "auto");
        wr(ADDR_CONTROL, 8'h50);
        #1;
        flag(autoActive, 1'b0, "auto");
        rd(ADDR_EVENT, 8'h01, 8'h0f);
        wr(ADDR_EVENT, 8'h0f);
        $display("test toggle done");
        // one pass per firmware intrusion: fifo access, then endpoint
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CONTROL, 8'h90);
            @(posedge ref_clk);
            #1;
            flag(autoActive, 1'b1, "auto");
            @(posedge ref_clk);
            fifoAccess <= (i == 0);
            epRegAccess <= (i == 1);
            @(posedge ref_clk);
            {fifoAccess, epRegAccess} <= 2'b00;
            #1;
            flag(autoActive, 1'b0, "auto");
            rd(ADDR_EVENT, 8'h01, 8'h0f);
            wr(ADDR_EVENT, 8'h0f);
        end
        $display("test halt done");
        wr(ADDR_CONTROL, 8'h90);
        pkt(4'b1000, 7'h40);
        flag(retrySeen, 1'b1, "retry");
        rd(ADDR_EVENT, 8'h00, 8'h0f);
        pkt(4'b1010, 7'h40);
        wr(ADDR_CONTROL, 8'h80);
        flag(autoActive, 1'b1, "auto");
        repeat (12) @(posedge ref_clk);
        #1;
        flag(autoActive, 1'b0, "auto");
        rd(ADDR_EVENT, 8'h01, 8'h0f);
        rd(ADDR_MIRROR, 8'ha5, 8'hff);
        rd(ADDR_MIRROR, 8'ha5, 8'hff);
        wr(ADDR_CONTROL, 8'h01);
        rd(ADDR_MIRROR, 8'h5a, 8'hff);
        rd(4'hf, 8'h00, 8'hff);
        $display("test drain done");
        summarize();
    end
endmodule
`default_nettype wire
